// [lbp_consts.vh]
// Constants shared by the local bus phasing block
`ifndef LBP_CONSTS_VH
`define LBP_CONSTS_VH

// Region codes carried with each request
`define LBP_REGION_LOWER   2'h0
`define LBP_REGION_MIDDLE  2'h1
`define LBP_REGION_UPPER   2'h2
`define LBP_REGION_IO      2'h3

// Bit positions of width selects, set bit means 8-bit wide
`define LBP_AUX_IO_BIT     0
`define LBP_AUX_MIDDLE_BIT 1
`define LBP_AUX_LOWER_BIT  2
`define LBP_AUX_UPPER_BIT  3

// Byte selection codes of a request
`define LBP_BYTE_WORD      2'h0
`define LBP_BYTE_HIGH      2'h1
`define LBP_BYTE_LOW       2'h2

// Value shown on the multiplexed bus in a refresh address phase
`define LBP_REFRESH_DATA   16'hFFFF

// Lowest request address bits of DRAM row and column
`define LBP_ROW_LSB        10
`define LBP_COL_LSB        1

// Synchroniser edges before reset straps are valid
`define LBP_INIT_CAPTURE   2'h2

`endif

// [lbp_sync2.v]
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module lbp_sync2 #(
	parameter W = 1
) (
	// Clock and reset
	input  wire         mclk,
	input  wire         rst_n,
	// Pins and synchronised copies
	input  wire [W-1:0] pin_in,
	output reg  [W-1:0] sync_out
);

	reg [W-1:0] meta;

	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			meta     <= {W{1'b0}};
			sync_out <= {W{1'b0}};
		end else begin
			meta     <= pin_in;
			sync_out <= meta;
		end
	end

endmodule // lbp_sync2

// [lbp_lane_enc.v]
// Byte lane encoding of a bus cycle
`timescale 1ns/1ps
`include "lbp_consts.vh"
module lbp_lane_enc (
	// Request
	input  wire [1:0] byte_sel,
	input  wire       narrow,
	input  wire       refresh,
	// Encoded lanes
	output reg        bhe_n,
	output reg        ad0,
	output reg        use_hi,
	output reg        use_lo,
	output reg        hi_on_lo
);

	always @* begin
		bhe_n    = 1'b1;
		ad0      = 1'b0;
		use_hi   = 1'b0;
		use_lo   = 1'b0;
		hi_on_lo = 1'b0;
		if (refresh) begin
			// (RULE19) refresh marked 1/1
			bhe_n = 1'b1;
			ad0   = 1'b1;
		end else begin
			// (RULE17) lane code table
			case (byte_sel)
			`LBP_BYTE_WORD: begin
				bhe_n  = 1'b0;
				ad0    = 1'b0;
				use_hi = 1'b1;
				use_lo = 1'b1;
			end
			`LBP_BYTE_HIGH: begin
				bhe_n  = 1'b0;
				ad0    = 1'b1;
				use_hi = 1'b1;
			end
			default: begin
				bhe_n  = 1'b1;
				ad0    = 1'b0;
				use_lo = 1'b1;
			end
			endcase
			// (RULE11) narrow moves high byte low
			if (narrow) begin
				hi_on_lo = use_hi;
				use_lo   = 1'b1;
				use_hi   = 1'b0;
			end
		end
	end

endmodule // lbp_lane_enc

// [lbp_bus_phaser.v]
// Local bus cycle sequencer with address and data phasing
// Overview of operation
// (RULE1) Nonmux address leads multiplexed address by half a bus clock.
// (RULE2) All address outputs float during bus hold and reset.
// (RULE3) DRAM: odd address pins give row then column; others hold still.
// (RULE4) Upper mux lines carry address in T1, data in T2 to T4.
// (RULE5) Lower mux lines carry low address byte in T1, then data.
// (RULE6) Upper mux lines float in T2 to T4 when upper strobe idle.
// (RULE7) Lower mux lines float in T2 to T4 when lower strobe idle.
// (RULE8) Reset configuration is captured from all sixteen mux lines.
// (RULE9) Eight-bit regions keep address on upper mux lines throughout.
// (RULE10) Dropped address in 8-bit mode: upper float T1, address after.
// (RULE11) Eight-bit mode moves both data bytes over lower mux lines; a word cycle here moves only the high byte.
// (RULE12) Address latch strobe pulses while address is valid on bus.
// (RULE13) Address latch strobe floats in pin-float test mode.
// (RULE14) Strobe floats low in hold, weakly pulled low in reset.
// (RULE15) Async ready is active high; unsynchronised edges may add a cycle.
// (RULE16) Async ready low defers to sync ready; high forces ready.
// (RULE17) Upper enable and address bit 0 encode word, high, low.
// (RULE18) Upper enable driven T1 through T3 and waits; floats in hold.
// (RULE19) Refresh: enable and bit 0 high, FFFF on bus in T1.
// (RULE20) Strap high: region drop bit removes T1 address on selects.
// (RULE21) Strap low: address always driven; strap sampled at reset release.
// (RULE22) Strap low puts status and zero indicator pins to normal use.
// (RULE23) Four width selects size each memory region and I/O space.
// (RULE24) Wait phases follow T3 while selected ready is low.
`timescale 1ns/1ps
`include "lbp_consts.vh"
module lbp_bus_phaser (
	// Clock and reset
	input  wire        mclk,
	input  wire        rst_n,
	// Cycle request
	input  wire        cyc_start,
	input  wire        cyc_write,
	input  wire        cyc_refresh,
	input  wire        cyc_dram,
	input  wire [1:0]  cyc_region,
	input  wire [1:0]  cyc_byte,
	input  wire [19:0] cyc_addr,
	input  wire [15:0] cyc_wdata,
	// Cycle answer
	output reg         cyc_accept,
	output reg         cyc_busy,
	output reg         cyc_done,
	output reg  [15:0] cyc_rdata,
	// Configuration
	input  wire [3:0]  auxiliary_config_reg,
	input  wire        lower_address_drop_bit,
	input  wire        upper_address_drop_bit,
	input  wire        pin_float_test_mode,
	// Bus hold
	input  wire        hold_req,
	output reg         hold_ack,
	// Address pins
	output reg  [19:0] nonmux_address_out,
	output reg         nonmux_address_oe,
	input  wire [15:0] mux_addr_data_bus_in,
	output reg  [15:0] mux_addr_data_bus_out,
	output reg         mux_hi_oe,
	output reg         mux_lo_oe,
	// Byte enable pin, also the strap input
	output reg         upper_byte_enable_n_out,
	output reg         upper_byte_enable_n_oe,
	input  wire        address_phase_strap_n,
	// Write strobes
	output reg         upper_write_strobe_n,
	output reg         lower_write_strobe_n,
	output reg         write_strobe_oe,
	// Address latch strobe
	output reg         ale_out,
	output reg         ale_oe,
	output reg         ale_pull_low,
	// Ready and clock
	input  wire        async_ready_in,
	input  wire        sync_ready_in,
	output reg         system_clock_out,
	// Reset straps
	output reg  [15:0] reset_config_value,
	output reg         address_phase_always,
	output reg         status_pins_normal
);

	localparam [2:0] ST_IDLE = 3'h0;
	localparam [2:0] ST_LEAD = 3'h1;
	localparam [2:0] ST_T1   = 3'h2;
	localparam [2:0] ST_T2   = 3'h3;
	localparam [2:0] ST_T3   = 3'h4;
	localparam [2:0] ST_TW   = 3'h5;
	localparam [2:0] ST_T4   = 3'h6;
	localparam [2:0] ST_HOLD = 3'h7;

	// Spread nine bits over the odd address pins
	function [19:0] odd_spread;
		input [19:0] base;
		input [8:0]  bits;
		integer      i;
		begin
			odd_spread = base;
			for (i = 0; i < 9; i = i + 1)
				odd_spread[2*i+1] = bits[i];
		end
	endfunction

	wire [20:0] pin_sync;
	wire [15:0] ad_s     = pin_sync[15:0];
	wire        strap_s  = pin_sync[16];
	wire        float_s  = pin_sync[17];
	wire        hold_s   = pin_sync[18];
	wire        sync_ready_in_s   = pin_sync[19];
	wire        async_ready_in_s   = pin_sync[20];

	// (RULE15) ready pins through two flops
	lbp_sync2 #(.W(21)) u_sync (
		.mclk     (mclk),
		.rst_n    (rst_n),
		.pin_in   ({async_ready_in, sync_ready_in, hold_req,
		            pin_float_test_mode, address_phase_strap_n,
		            mux_addr_data_bus_in}),
		.sync_out (pin_sync)
	);

	reg  [2:0]  st;
	reg  [2:0]  next_st;
	reg         half;
	reg  [1:0]  init_cnt;
	reg         cfg_done;
	reg         strap_hi;
	reg         r_write, r_refresh, r_dram, r_narrow, r_drop;
	reg  [1:0]  r_byte;
	reg  [19:0] r_addr;
	reg  [15:0] r_wdata;

	wire        phase_end = half;
	wire        take      = (st == ST_IDLE) && cfg_done && !hold_s &&
	                        cyc_start && !half;
	// (RULE16) either ready input completes
	wire        ready     = async_ready_in_s | sync_ready_in_s;
	wire        in_data   = (st == ST_T2) || (st == ST_T3) ||
	                        (st == ST_TW) || (st == ST_T4);
	wire        in_strobe = (st == ST_T2) || (st == ST_T3) ||
	                        (st == ST_TW);
	wire        active    = (st != ST_IDLE) && (st != ST_HOLD);

	// (RULE23) width select per space
	wire        req_narrow =
		(cyc_region == `LBP_REGION_UPPER)  ?
			auxiliary_config_reg[`LBP_AUX_UPPER_BIT] :
		(cyc_region == `LBP_REGION_LOWER)  ?
			auxiliary_config_reg[`LBP_AUX_LOWER_BIT] :
		(cyc_region == `LBP_REGION_MIDDLE) ?
			auxiliary_config_reg[`LBP_AUX_MIDDLE_BIT] :
			auxiliary_config_reg[`LBP_AUX_IO_BIT];

	// (RULE20) drop bit only on select regions
	wire        req_drop = strap_hi && !cyc_refresh &&
		(((cyc_region == `LBP_REGION_LOWER) && lower_address_drop_bit) ||
		 ((cyc_region == `LBP_REGION_UPPER) && upper_address_drop_bit));

	wire        bhe_n, ad0, use_hi, use_lo, hi_on_lo;

	lbp_lane_enc u_lane (
		.byte_sel (r_byte),
		.narrow   (r_narrow),
		.refresh  (r_refresh),
		.bhe_n    (bhe_n),
		.ad0      (ad0),
		.use_hi   (use_hi),
		.use_lo   (use_lo),
		.hi_on_lo (hi_on_lo)
	);

	// Sequencer
	always @* begin
		next_st = st;
		case (st)
		ST_IDLE: begin
			if (cfg_done && hold_s)
				next_st = ST_HOLD;
			else if (take)
				next_st = ST_LEAD;
		end
		ST_HOLD: if (!hold_s) next_st = ST_IDLE;
		// (RULE1) half period address lead
		ST_LEAD: next_st = ST_T1;
		ST_T1:   if (phase_end) next_st = ST_T2;
		ST_T2:   if (phase_end) next_st = ST_T3;
		// (RULE24) wait while not ready
		ST_T3, ST_TW: begin
			if (phase_end)
				next_st = ready ? ST_T4 : ST_TW;
		end
		ST_T4:   if (phase_end) next_st = ST_IDLE;
		default: next_st = ST_IDLE;
		endcase
	end

	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			st        <= ST_IDLE;
			half      <= 1'b0;
			r_write   <= 1'b0;
			r_refresh <= 1'b0;
			r_dram    <= 1'b0;
			r_narrow  <= 1'b0;
			r_drop    <= 1'b0;
			r_byte    <= `LBP_BYTE_WORD;
			r_addr    <= 20'h00000;
			r_wdata   <= 16'h0000;
		end else begin
			st   <= next_st;
			half <= ~half;
			if (take) begin
				r_write   <= cyc_write && !cyc_refresh;
				r_refresh <= cyc_refresh;
				r_dram    <= cyc_dram && !cyc_refresh;
				r_narrow  <= req_narrow && !cyc_refresh;
				r_drop    <= req_drop;
				r_byte    <= cyc_byte;
				r_addr    <= cyc_addr;
				r_wdata   <= cyc_wdata;
			end
		end
	end

	// Reset strap and configuration capture
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			init_cnt             <= 2'h0;
			cfg_done             <= 1'b0;
			strap_hi             <= 1'b1;
			reset_config_value   <= 16'h0000;
			address_phase_always <= 1'b0;
			status_pins_normal   <= 1'b0;
		end else if (!cfg_done) begin
			init_cnt <= init_cnt + 2'h1;
			if (init_cnt == `LBP_INIT_CAPTURE) begin
				cfg_done <= 1'b1;
				// (RULE8) capture all mux lines
				reset_config_value   <= ad_s;
				// (RULE21) strap sampled at release
				strap_hi             <= strap_s;
				address_phase_always <= !strap_s;
				// (RULE22) strap low frees status pins
				status_pins_normal   <= !strap_s;
			end
		end
	end

	// Pin values ahead of their output flops
	reg  [19:0] next_addr;
	reg  [15:0] next_ad;
	reg         next_addr_oe, next_hi_oe, next_lo_oe, next_bhe;
	reg         next_bhe_oe, next_whb, next_wlb, next_ale;
	reg  [15:0] ad_addr;
	reg  [8:0]  dram_bits;

	always @* begin
		ad_addr   = r_refresh ? `LBP_REFRESH_DATA :
		            {r_addr[15:1], ad0};
		dram_bits = 9'h000;
		// (RULE3) row then column on odd pins
		if ((st == ST_LEAD) || (st == ST_T1) || (st == ST_T2))
			dram_bits = r_addr[`LBP_ROW_LSB +: 9];
		else
			dram_bits = r_addr[`LBP_COL_LSB +: 9];
		next_addr = r_dram ? odd_spread(r_addr, dram_bits) : r_addr;
		// (RULE2) address floats outside own cycles
		next_addr_oe = active;
		next_ad      = 16'h0000;
		next_hi_oe   = 1'b0;
		next_lo_oe   = 1'b0;
		if (st == ST_T1 && !r_drop) begin
			// (RULE4) upper address in T1
			// (RULE5) low address byte in T1
			next_ad    = ad_addr;
			next_hi_oe = 1'b1;
			next_lo_oe = 1'b1;
		end else if (in_data && r_write) begin
			// (RULE7) lower data only with strobe
			next_lo_oe    = use_lo;
			// (RULE11) high byte via lower lines
			next_ad[7:0]  = hi_on_lo ? r_wdata[15:8] : r_wdata[7:0];
			// (RULE6) upper data only with strobe
			next_hi_oe    = use_hi;
			next_ad[15:8] = r_wdata[15:8];
		end
		// (RULE9) narrow keeps upper address
		if (r_narrow && (st == ST_T1) && !r_drop) begin
			next_ad[15:8] = r_addr[15:8];
			next_hi_oe    = 1'b1;
		end
		// (RULE10) dropped phase, address from T2
		if (r_narrow && in_data) begin
			next_ad[15:8] = r_addr[15:8];
			next_hi_oe    = 1'b1;
		end
		// (RULE18) enable from T1 through waits
		next_bhe    = ((st == ST_T1) || (st == ST_T2) ||
		               (st == ST_T3) || (st == ST_TW)) ? bhe_n : 1'b1;
		next_bhe_oe = active;
		next_whb    = !(in_strobe && r_write && use_hi);
		next_wlb    = !(in_strobe && r_write && use_lo);
		// (RULE12) strobe while address on bus
		next_ale    = (st == ST_T1) && !half && !r_drop;
	end

	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			nonmux_address_out      <= 20'h00000;
			nonmux_address_oe       <= 1'b0;
			mux_addr_data_bus_out   <= 16'h0000;
			mux_hi_oe               <= 1'b0;
			mux_lo_oe               <= 1'b0;
			upper_byte_enable_n_out <= 1'b1;
			upper_byte_enable_n_oe  <= 1'b0;
			upper_write_strobe_n    <= 1'b1;
			lower_write_strobe_n    <= 1'b1;
			write_strobe_oe         <= 1'b0;
			ale_out                 <= 1'b0;
			ale_oe                  <= 1'b0;
			ale_pull_low            <= 1'b1;
			hold_ack                <= 1'b0;
			system_clock_out        <= 1'b0;
		end else begin
			nonmux_address_out      <= next_addr;
			nonmux_address_oe       <= next_addr_oe;
			mux_addr_data_bus_out   <= next_ad;
			mux_hi_oe               <= next_hi_oe;
			mux_lo_oe               <= next_lo_oe;
			upper_byte_enable_n_out <= next_bhe;
			upper_byte_enable_n_oe  <= next_bhe_oe;
			upper_write_strobe_n    <= next_whb;
			lower_write_strobe_n    <= next_wlb;
			write_strobe_oe         <= next_addr_oe;
			ale_out                 <= next_ale;
			// (RULE13) float in pin test mode
			// (RULE14) float low in hold
			ale_oe                  <= !float_s && (st != ST_HOLD);
			ale_pull_low            <= (st == ST_HOLD);
			hold_ack                <= (st == ST_HOLD);
			system_clock_out        <= !half;
		end
	end

	// Cycle answer
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cyc_accept <= 1'b0;
			cyc_busy   <= 1'b0;
			cyc_done   <= 1'b0;
			cyc_rdata  <= 16'h0000;
		end else begin
			cyc_accept <= take;
			cyc_busy   <= active || take;
			cyc_done   <= (st == ST_T4) && phase_end;
			if ((st == ST_T4) && phase_end && !r_write && !r_refresh) begin
				if (!r_narrow)
					cyc_rdata <= ad_s;
				else if (hi_on_lo)
					cyc_rdata[15:8] <= ad_s[7:0];
				else
					cyc_rdata[7:0] <= ad_s[7:0];
			end
		end
	end

endmodule // lbp_bus_phaser

// [lbp_phaser_monitor.sv]
// Port checker of the local bus phaser
`timescale 1ns/1ps
module lbp_phaser_monitor (
	// Clock, reset and controls
	input wire        mclk,
	input wire        rst_n,
	input wire        cyc_busy,
	input wire        cyc_done,
	input wire        cyc_write,
	input wire        cyc_refresh,
	input wire        cyc_dram,
	input wire        hold_ack,
	input wire        system_clock_out,
	input wire        pin_float_test_mode,
	input wire        async_ready_in,
	input wire        sync_ready_in,
	// Bus pins
	input wire [19:0] nonmux_address_out,
	input wire        nonmux_address_oe,
	input wire [15:0] mux_addr_data_bus_out,
	input wire        mux_hi_oe,
	input wire        mux_lo_oe,
	input wire        upper_byte_enable_n_out,
	input wire        upper_byte_enable_n_oe,
	input wire        ale_out,
	input wire        ale_oe,
	input wire        ale_pull_low
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	wire rfsh = upper_byte_enable_n_out & mux_addr_data_bus_out[0];
	hold_float_a: assert property (
		hold_ack && $past(hold_ack) |-> !nonmux_address_oe && !mux_hi_oe
		&& !mux_lo_oe && !upper_byte_enable_n_oe) else $error("bus in hold");
	ale_hold_a: assert property (
		hold_ack && $past(hold_ack) |-> !ale_oe && ale_pull_low)
		else $error("strobe in hold");
	ale_test_a: assert property (
		pin_float_test_mode [*4] |-> !ale_oe) else $error("strobe driven");
	ale_valid_a: assert property (
		$fell(ale_out) |-> mux_lo_oe && $stable(mux_addr_data_bus_out))
		else $error("address gone at strobe end");
	addr_lead_a: assert property (
		$rose(ale_out) && !rfsh && !cyc_dram |->
		$past(nonmux_address_oe) &&
		mux_addr_data_bus_out[7:0] == nonmux_address_out[7:0])
		else $error("address lead");
	refresh_a: assert property (
		$rose(ale_out) && cyc_refresh |-> rfsh &&
		mux_addr_data_bus_out == 16'hFFFF) else $error("refresh mark");
	bhe_steady_a: assert property (
		$rose(ale_out) |=> (upper_byte_enable_n_oe &&
		$stable(upper_byte_enable_n_out)) [*4]) else $error("enable moved");
	read_float_a: assert property (
		(cyc_busy && !cyc_write && mux_lo_oe) [*2] |=> !mux_lo_oe)
		else $error("lower lines driven on read");
	ready_wait_a: assert property (
		(cyc_busy && !async_ready_in && !sync_ready_in) [*8] |-> !cyc_done)
		else $error("cycle ended unready");
	dram_even_a: assert property (
		nonmux_address_oe && $past(nonmux_address_oe) && !cyc_refresh |->
		$stable(nonmux_address_out & 20'hD5555))
		else $error("even address pins moved");
	clk_out_a: assert property (
		rst_n && $past(rst_n) |->
		system_clock_out != $past(system_clock_out))
		else $error("clock output stalled");
endmodule // lbp_phaser_monitor
bind lbp_bus_phaser lbp_phaser_monitor lbp_phaser_monitor_inst (.*);

// [lbp_bus_partner.sv]
// Memory and ready model on the far side of the bus
`timescale 1ns/1ps
module lbp_bus_partner (
	// Clock and reset
	input  wire        mclk,
	input  wire        rst_n,
	// Board lines and settings
	input  wire [15:0] bus,
	input  wire        ale,
	input  wire        bhe_n,
	input  wire        wr_hi_n,
	input  wire        wr_lo_n,
	input  wire [15:0] cfg_pat,
	input  wire [7:0]  waits,
	// Model outputs
	output reg  [15:0] drv,
	output reg         sync_rdy,
	output reg  [15:0] lat_addr,
	output reg         lat_bhe_n,
	output reg  [7:0]  ale_cnt
);
	reg  [15:0] mem [0:15];
	reg  [7:0]  cnt;
	reg         ale_q;
	reg         act;
	wire [3:0]  idx = lat_addr[4:1];
	wire [15:0] rd = mem[idx];
	always @(posedge mclk) begin
		if (!wr_lo_n)
			mem[idx][7:0] <= bus[7:0];
		if (!wr_hi_n)
			mem[idx][15:8] <= bus[15:8];
	end
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			drv <= cfg_pat;
			ale_q <= 1'b0;
			act <= 1'b0;
			cnt <= 8'hFF;
			sync_rdy <= 1'b1;
			lat_addr <= 16'h0000;
			lat_bhe_n <= 1'b1;
			ale_cnt <= 8'h00;
		end else begin
			ale_q <= ale;
			sync_rdy <= cnt >= waits;
			if (ale && !ale_q)
				cnt <= 8'h00;
			else if (cnt != 8'hFF)
				cnt <= cnt + 8'h01;
			if (!ale && ale_q) begin
				lat_addr <= bus;
				lat_bhe_n <= bhe_n;
				ale_cnt <= ale_cnt + 8'h01;
				act <= 1'b1;
			end else if (cnt == waits + 8'h0C)
				act <= 1'b0;
			// Strap pattern until the first cycle, then data or noise
			if (ale_cnt == 8'h00)
				drv <= cfg_pat;
			else if (act && wr_hi_n && wr_lo_n)
				drv <= {rd[15:8], lat_addr[0] ? rd[15:8] : rd[7:0]};
			else
				drv <= ~drv;
		end
	end
endmodule // lbp_bus_partner

// [local_bus_addr_data_phasing_tb_top.sv]
// Self-checking bench of the local bus phaser
`timescale 1ns/1ps
`include "lbp_consts.vh"
module local_bus_addr_data_phasing_tb_top;
	reg         mclk, rst_n, cyc_start, cyc_write, cyc_refresh, cyc_dram;
	reg  [1:0]  cyc_region, cyc_byte;
	reg  [19:0] cyc_addr;
	reg  [15:0] cyc_wdata, cfg_pat;
	reg  [3:0]  auxiliary_config_reg;
	reg         lower_address_drop_bit, upper_address_drop_bit, hold_req;
	reg         pin_float_test_mode, address_phase_strap_n, async_ready_in;
	reg  [7:0]  waits;
	wire        cyc_accept, cyc_busy, cyc_done, hold_ack, nonmux_address_oe;
	wire        mux_hi_oe, mux_lo_oe, upper_byte_enable_n_out, ale_out, ale_oe;
	wire        upper_byte_enable_n_oe, upper_write_strobe_n, write_strobe_oe;
	wire        lower_write_strobe_n, ale_pull_low, system_clock_out;
	wire        address_phase_always, status_pins_normal, sync_ready_in;
	wire        lat_bhe_n;
	wire [15:0] cyc_rdata, mux_addr_data_bus_out, reset_config_value, drv;
	wire [15:0] lat_addr;
	wire [19:0] nonmux_address_out;
	wire [7:0]  ale_cnt;
	integer     failures, n_compared, dur, cycles;
	// Board level of shared lines
	wire [15:0] mux_addr_data_bus_in = {
		mux_hi_oe ? mux_addr_data_bus_out[15:8] : drv[15:8],
		mux_lo_oe ? mux_addr_data_bus_out[7:0] : drv[7:0]};
	wire        bhe_pin = !upper_byte_enable_n_oe | upper_byte_enable_n_out;
	lbp_bus_phaser lbp_bus_phaser_inst (.*);
	lbp_bus_partner lbp_bus_partner_inst (.mclk(mclk), .rst_n(rst_n),
		.bus(mux_addr_data_bus_in), .ale(ale_oe & ale_out), .bhe_n(bhe_pin),
		.wr_hi_n(!write_strobe_oe | upper_write_strobe_n),
		.wr_lo_n(!write_strobe_oe | lower_write_strobe_n),
		.cfg_pat(cfg_pat), .waits(waits), .drv(drv), .sync_rdy(sync_ready_in),
		.lat_addr(lat_addr), .lat_bhe_n(lat_bhe_n), .ale_cnt(ale_cnt));
	task check(input [31:0] seen, input [31:0] exp);
		begin
			n_compared = n_compared + 1;
			if (seen !== exp) begin
				failures = failures + 1;
				$display("MISMATCH %0t seen %h want %h", $time, seen, exp);
			end
		end
	endtask
	task end_of_test;
		begin
			$display("compared %0d failures %0d", n_compared, failures);
			if (failures == 0 && n_compared > 0)
				$display("bench passed");
			else
				$display("bench failed");
			$finish;
		end
	endtask
	task do_reset(input s, input [15:0] p);
		begin
			@(posedge mclk);
			rst_n <= 1'b0;
			address_phase_strap_n <= s;
			cfg_pat <= p;
			repeat (16) @(posedge mclk);
			rst_n <= 1'b1;
			repeat (8) @(posedge mclk);
			#1;
			check(reset_config_value, p);
			check(address_phase_always, !s);
			check(status_pins_normal, !s);
		end
	endtask
	task run(input w, input [1:0] rg, input [1:0] b, input [19:0] a,
		input [15:0] d, input rf);
		integer i;
		begin
			@(posedge mclk);
			cyc_start <= 1'b1;
			cyc_write <= w;
			cyc_region <= rg;
			cyc_byte <= b;
			cyc_addr <= a;
			cyc_wdata <= d;
			cyc_refresh <= rf;
			for (i = 0; i < 40 && cyc_accept !== 1'b1; i = i + 1)
				@(posedge mclk) #1;
			@(posedge mclk) cyc_start <= 1'b0;
			for (dur = 0; dur < 200 && cyc_done !== 1'b1; dur = dur + 1)
				@(posedge mclk) #1;
			check(cyc_done, 1'b1);
		end
	endtask
	task t_word;
		begin
			run(1'b1, `LBP_REGION_LOWER, `LBP_BYTE_WORD, 20'h30A46, 16'h1234, 1'b0);
			check(lat_addr[7:0], 8'h46);
			check(lat_addr[15:8], 8'h0A);
			run(1'b0, `LBP_REGION_LOWER, `LBP_BYTE_WORD, 20'h30A46, 16'h0, 1'b0);
			check(cyc_rdata, 16'h1234);
		end
	endtask
	task t_lanes;
		integer b;
		begin
			for (b = 0; b < 3; b = b + 1) begin
				run(1'b1, `LBP_REGION_MIDDLE, b[1:0], {19'h00008, b == 1},
					16'h5AA5, 1'b0);
				check({lat_bhe_n, lat_addr[0]}, b);
			end
		end
	endtask
	task t_narrow;
		begin
			run(1'b1, `LBP_REGION_UPPER, `LBP_BYTE_WORD, 20'hF0A20, 16'hBEEF, 1'b0);
			@(posedge mclk) auxiliary_config_reg <= 4'h8;
			run(1'b0, `LBP_REGION_UPPER, `LBP_BYTE_HIGH, 20'hF0A21, 16'h0, 1'b0);
			check(cyc_rdata[15:8], 8'hBE);
			check(lat_addr[15:8], 8'h0A);
			@(posedge mclk) auxiliary_config_reg <= 4'h0;
		end
	endtask
	task t_waits;
		integer d0;
		begin
			run(1'b1, `LBP_REGION_IO, `LBP_BYTE_WORD, 20'h00100, 16'h0F0F, 1'b0);
			d0 = dur;
			@(posedge mclk) waits <= 8'd10;
			run(1'b1, `LBP_REGION_IO, `LBP_BYTE_WORD, 20'h00100, 16'h0F0F, 1'b0);
			check(dur >= d0 + 8, 1);
			@(posedge mclk) async_ready_in <= 1'b1;
			run(1'b1, `LBP_REGION_IO, `LBP_BYTE_WORD, 20'h00100, 16'h0F0F, 1'b0);
			check(dur, d0);
			@(posedge mclk) async_ready_in <= 1'b0;
			waits <= 8'd0;
		end
	endtask
	task t_refresh;
		begin
			run(1'b0, `LBP_REGION_LOWER, `LBP_BYTE_WORD, 20'h0, 16'h0, 1'b1);
			check(lat_addr, 16'hFFFF);
			check(lat_bhe_n, 1'b1);
		end
	endtask
	task t_hold;
		integer i;
		begin
			@(posedge mclk) hold_req <= 1'b1;
			for (i = 0; i < 20 && hold_ack !== 1'b1; i = i + 1)
				@(posedge mclk) #1;
			repeat (2) @(posedge mclk);
			#1;
			check(mux_lo_oe | mux_hi_oe | nonmux_address_oe, 1'b0);
			check(ale_pull_low, 1'b1);
			@(posedge mclk) hold_req <= 1'b0;
			repeat (6) @(posedge mclk);
			#1;
			check(hold_ack, 1'b0);
		end
	endtask
	task t_float;
		reg [7:0] n;
		begin
			@(posedge mclk) pin_float_test_mode <= 1'b1;
			n = ale_cnt;
			run(1'b1, `LBP_REGION_MIDDLE, `LBP_BYTE_WORD, 20'h00200, 16'h1111, 1'b0);
			check(ale_cnt, n);
			@(posedge mclk) pin_float_test_mode <= 1'b0;
		end
	endtask
	task t_drop;
		reg [7:0] n;
		begin
			do_reset(1'b1, 16'hC3A5);
			n = ale_cnt;
			run(1'b1, `LBP_REGION_LOWER, `LBP_BYTE_WORD, 20'h00300, 16'h2222, 1'b0);
			check(ale_cnt, n);
			run(1'b1, `LBP_REGION_MIDDLE, `LBP_BYTE_WORD, 20'h00300, 16'h2222, 1'b0);
			check(ale_cnt, n + 8'h01);
		end
	endtask
	task t_dram;
		reg [19:0] a, row_pins, col_pins;
		integer i;
		begin
			a = 20'h5A3C6;
			row_pins = a;
			col_pins = a;
			for (i = 0; i < 9; i = i + 1) begin
				row_pins[2*i+1] = a[`LBP_ROW_LSB + i];
				col_pins[2*i+1] = a[`LBP_COL_LSB + i];
			end
			@(posedge mclk) cyc_dram <= 1'b1;
			fork
				run(1'b1, `LBP_REGION_MIDDLE, `LBP_BYTE_WORD, a,
					16'h3C3C, 1'b0);
				begin
					@(posedge ale_out) #1;
					check(nonmux_address_out, row_pins);
					@(posedge cyc_done) #1;
					check(nonmux_address_out, col_pins);
				end
			join
			@(posedge mclk) cyc_dram <= 1'b0;
		end
	endtask
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cycles = cycles + 1;
		if (cycles == 6000) begin
			failures = failures + 1;
			end_of_test;
		end
	end
	initial begin
		{rst_n, cyc_start, cyc_write, cyc_refresh, cyc_dram, hold_req} = 6'h00;
		{cyc_region, cyc_byte, auxiliary_config_reg, waits} = 16'h0000;
		{cyc_addr, cyc_wdata, cfg_pat} = 52'h0;
		{lower_address_drop_bit, upper_address_drop_bit} = 2'h3;
		{pin_float_test_mode, address_phase_strap_n, async_ready_in} = 3'h0;
		{failures, n_compared, cycles} = 96'h0;
		do_reset(1'b0, 16'h5A3C);
		t_word;
		t_lanes;
		t_narrow;
		t_waits;
		t_refresh;
		t_hold;
		t_float;
		t_dram;
		t_drop;
		end_of_test;
	end
endmodule // local_bus_addr_data_phasing_tb_top
